// ---- inc/crl_pkg.sv ----
/*
 Constants, types and state-to-mask lookup for the coherent read
 line-state update block. Assumes one clock domain and a single user.
*/
package crl_pkg;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		CRL_VACANT,
		CRL_UNIQUE_CLEAN,
		CRL_UNIQUE_DIRTY,
		CRL_SHARED_CLEAN,
		CRL_SHARED_DIRTY
	} crl_state_t;

	typedef enum logic [1:0] {
		CRL_RD_NOSNOOP,
		CRL_RD_ONCE,
		CRL_RD_CLEAN
	} crl_op_t;

	// ****************************************
	// Constants
	// ****************************************
	localparam int CRL_LINES = 16;
	localparam int CRL_IDX_W = 4;
	// Legal set bit positions in a five-bit mask
	localparam int CRL_B_I = 0;
	localparam int CRL_B_UC = 1;
	localparam int CRL_B_UD = 2;
	localparam int CRL_B_SC = 3;
	localparam int CRL_B_SD = 4;
	localparam logic [4:0] CRL_M_NONE = 5'h00;
	localparam logic [4:0] CRL_M_I = 5'h01;
	localparam logic [4:0] CRL_M_UC = 5'h02;
	localparam logic [4:0] CRL_M_UD = 5'h04;
	localparam logic [4:0] CRL_M_SC = 5'h08;
	localparam logic [4:0] CRL_M_SD = 5'h10;
	localparam logic [1:0] CRL_RESP_00 = 2'h0;
	localparam logic [1:0] CRL_RESP_10 = 2'h2;

	function automatic logic [4:0] crl_bit(input crl_state_t s);
		case (s)
			CRL_VACANT: crl_bit = CRL_M_I;
			CRL_UNIQUE_CLEAN: crl_bit = CRL_M_UC;
			CRL_UNIQUE_DIRTY: crl_bit = CRL_M_UD;
			CRL_SHARED_CLEAN: crl_bit = CRL_M_SC;
			default: crl_bit = CRL_M_SD;
		endcase
	endfunction

endpackage

// ---- rtl/crl_line_mem.sv ----
/*
 Line-state store: one write port, one registered read port.
 Assumes write and read come from the same clock; reset clears all lines.
*/
`timescale 1ns/1ps
module crl_line_mem #(
	parameter int LINES = crl_pkg::CRL_LINES,
	parameter int IDX_W = crl_pkg::CRL_IDX_W
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic we,
	input wire logic [IDX_W-1:0] widx,
	input crl_pkg::crl_state_t wdata,
	input wire logic [IDX_W-1:0] ridx,
	output crl_pkg::crl_state_t rdata
);
	crl_pkg::crl_state_t mem [LINES];
	crl_pkg::crl_state_t next_mem [LINES];
	crl_pkg::crl_state_t next_rdata;

	always_comb begin
		next_mem = mem;
		if (we) begin
			next_mem[widx] = wdata;
		end
		next_rdata = next_mem[ridx];
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < LINES; i++) begin
				mem[i] <= crl_pkg::CRL_VACANT;
			end
			rdata <= crl_pkg::CRL_VACANT;
		end else begin
			mem <= next_mem;
			rdata <= next_rdata;
		end
	end
endmodule

// ---- rtl/crl_update.sv ----
/*
 Coherent read line-state update: tracks one outstanding read, applies
 snoop changes to the line, then updates it from the response.
 Assumes the interconnect keeps the response bits stable while valid.
*/
`timescale 1ns/1ps
module crl_update #(
	parameter int IDX_W = crl_pkg::CRL_IDX_W
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic snoop_filter,
	input wire logic use_expected,
	input crl_pkg::crl_state_t pick_state,
	input wire logic req_valid,
	input crl_pkg::crl_op_t req_op,
	input wire logic [IDX_W-1:0] req_idx,
	input wire logic req_spec,
	output logic req_ready,
	output logic req_refused,
	input wire logic snoop_valid,
	input wire logic [IDX_W-1:0] snoop_idx,
	input crl_pkg::crl_state_t snoop_state,
	input wire logic resp_valid,
	input wire logic resp_last,
	input wire logic [1:0] resp_bits,
	output logic resp_ready,
	output logic rack,
	output crl_pkg::crl_state_t end_state,
	output logic [4:0] expected_set,
	output logic [4:0] legal_set,
	output logic proto_err,
	output logic start_err,
	output logic busy
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rst_s1;
	logic rst_s2;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end

	// ****************************************
	// End-state table
	// ****************************************
	// Returns {expected, legal with filter, legal without filter}
	function automatic logic [14:0] crl_table(input crl_pkg::crl_op_t op,
		input crl_pkg::crl_state_t s, input logic [1:0] r);
		logic [4:0] e;
		logic [4:0] f;
		logic [4:0] n;
		e = crl_pkg::CRL_M_NONE;
		f = crl_pkg::CRL_M_NONE;
		n = crl_pkg::CRL_M_NONE;
		if (op == crl_pkg::CRL_RD_NOSNOOP && r == crl_pkg::CRL_RESP_00) begin
			if (s == crl_pkg::CRL_UNIQUE_DIRTY || s == crl_pkg::CRL_SHARED_DIRTY) begin
				e = crl_pkg::CRL_M_UD;
				f = crl_pkg::CRL_M_UD | crl_pkg::CRL_M_SD;
			end else begin
				e = crl_pkg::CRL_M_I | crl_pkg::CRL_M_UC;
				f = crl_pkg::CRL_M_I | crl_pkg::CRL_M_UC | crl_pkg::CRL_M_SC;
			end
			n = f;
		end else if (op != crl_pkg::CRL_RD_NOSNOOP && r == crl_pkg::CRL_RESP_00) begin
			case (s)
				crl_pkg::CRL_VACANT: begin
					e = (op == crl_pkg::CRL_RD_ONCE) ? crl_pkg::CRL_M_I : crl_pkg::CRL_M_UC;
				end
				crl_pkg::CRL_UNIQUE_CLEAN, crl_pkg::CRL_SHARED_CLEAN: e = crl_pkg::CRL_M_UC;
				default: e = crl_pkg::CRL_M_UD;
			endcase
		end else if (op != crl_pkg::CRL_RD_NOSNOOP && r == crl_pkg::CRL_RESP_10) begin
			case (s)
				crl_pkg::CRL_VACANT: begin
					e = (op == crl_pkg::CRL_RD_ONCE) ? crl_pkg::CRL_M_I : crl_pkg::CRL_M_SC;
				end
				crl_pkg::CRL_SHARED_CLEAN: e = crl_pkg::CRL_M_SC;
				crl_pkg::CRL_SHARED_DIRTY: e = crl_pkg::CRL_M_SD;
				default: e = crl_pkg::CRL_M_NONE;
			endcase
		end
		if (op != crl_pkg::CRL_RD_NOSNOOP) begin
			// Unique may be held shared; clean may drop to vacant without filter
			f = e | (e[crl_pkg::CRL_B_UC] ? crl_pkg::CRL_M_SC : crl_pkg::CRL_M_NONE)
				| (e[crl_pkg::CRL_B_UD] ? crl_pkg::CRL_M_SD : crl_pkg::CRL_M_NONE);
			n = f | ((f[crl_pkg::CRL_B_UC] | f[crl_pkg::CRL_B_SC]) ? crl_pkg::CRL_M_I
				: crl_pkg::CRL_M_NONE);
		end
		crl_table = {e, f, n};
	endfunction

	// ****************************************
	// Transaction tracking
	// ****************************************
	typedef enum logic [1:0] {CRL_IDLE, CRL_WAIT, CRL_LOOK, CRL_DONE} crl_phase_t;
	crl_phase_t phase;
	crl_phase_t next_phase;
	crl_pkg::crl_op_t op;
	crl_pkg::crl_op_t next_op;
	logic [IDX_W-1:0] idx;
	logic [IDX_W-1:0] next_idx;
	logic [1:0] resp;
	logic [1:0] next_resp;
	crl_pkg::crl_state_t next_end_state;
	logic [4:0] next_expected_set;
	logic [4:0] next_legal_set;
	logic next_proto_err;
	logic next_start_err;
	logic next_refused;
	logic we;
	logic [IDX_W-1:0] widx;
	crl_pkg::crl_state_t wdata;
	logic [IDX_W-1:0] ridx;
	crl_pkg::crl_state_t cur;
	logic [14:0] tab;
	logic [4:0] legal;
	logic snoop_hit;

	crl_line_mem #(.LINES(1 << IDX_W), .IDX_W(IDX_W)) u_mem (
		.mclk(mclk),
		.rst_b(rst_s2),
		.we(we),
		.widx(widx),
		.wdata(wdata),
		.ridx(ridx),
		.rdata(cur)
	);

	assign req_ready = (phase == CRL_IDLE);
	assign resp_ready = (phase == CRL_WAIT) && !snoop_hit;
	assign snoop_hit = snoop_valid && (snoop_idx == idx);
	assign busy = (phase != CRL_IDLE);
	assign tab = crl_table(op, cur, resp);
	assign legal = snoop_filter ? tab[9:5] : tab[4:0];

	always_comb begin
		next_phase = phase;
		next_op = op;
		next_idx = idx;
		next_resp = resp;
		next_end_state = end_state;
		next_expected_set = expected_set;
		next_legal_set = legal_set;
		next_proto_err = 1'b0;
		next_start_err = 1'b0;
		next_refused = 1'b0;
		we = 1'b0;
		widx = snoop_idx;
		wdata = snoop_state;
		ridx = idx;
		if (snoop_valid) begin
			we = 1'b1;
		end
		case (phase)
			CRL_IDLE: begin
				ridx = req_idx;
				if (req_valid) begin
					next_op = req_op;
					next_idx = req_idx;
					next_phase = CRL_WAIT;
				end
			end
			CRL_WAIT: begin
				if (resp_valid && resp_ready && resp_last) begin
					next_resp = resp_bits;
					next_phase = CRL_LOOK;
					next_proto_err = resp_bits[0]
						|| (op == crl_pkg::CRL_RD_NOSNOOP && resp_bits[1]);
				end
			end
			CRL_LOOK: begin
				next_expected_set = tab[14:10];
				next_legal_set = legal;
				if (legal == crl_pkg::CRL_M_NONE) begin
					next_start_err = 1'b1;
					next_end_state = cur;
				end else if (!use_expected && (legal & crl_pkg::crl_bit(pick_state)) != 5'h00) begin
					next_end_state = pick_state;
				end else if (tab[10 + crl_pkg::CRL_B_UD]) begin
					next_end_state = crl_pkg::CRL_UNIQUE_DIRTY;
				end else if (tab[10 + crl_pkg::CRL_B_SD]) begin
					next_end_state = crl_pkg::CRL_SHARED_DIRTY;
				end else if (tab[10 + crl_pkg::CRL_B_UC]) begin
					next_end_state = crl_pkg::CRL_UNIQUE_CLEAN;
				end else if (tab[10 + crl_pkg::CRL_B_SC]) begin
					next_end_state = crl_pkg::CRL_SHARED_CLEAN;
				end else begin
					next_end_state = crl_pkg::CRL_VACANT;
				end
				// A same-line snoop in the lookup cycle would be overwritten; it wins instead
				if (!snoop_hit) begin
					we = 1'b1;
					widx = idx;
					wdata = next_end_state;
				end
				next_phase = CRL_DONE;
			end
			default: begin
				next_phase = CRL_IDLE;
			end
		endcase
		if (phase == CRL_IDLE && req_valid && req_spec == 1'b0 && req_op == crl_pkg::CRL_RD_ONCE
			&& snoop_filter && 1'b0) begin
			next_refused = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_s2) begin
		if (!rst_s2) begin
			phase <= CRL_IDLE;
			op <= crl_pkg::CRL_RD_NOSNOOP;
			idx <= '0;
			resp <= crl_pkg::CRL_RESP_00;
			end_state <= crl_pkg::CRL_VACANT;
			expected_set <= crl_pkg::CRL_M_NONE;
			legal_set <= crl_pkg::CRL_M_NONE;
			proto_err <= 1'b0;
			start_err <= 1'b0;
			req_refused <= 1'b0;
		end else begin
			phase <= next_phase;
			op <= next_op;
			idx <= next_idx;
			resp <= next_resp;
			end_state <= next_end_state;
			expected_set <= next_expected_set;
			legal_set <= next_legal_set;
			proto_err <= next_proto_err;
			start_err <= next_start_err;
			req_refused <= next_refused;
		end
	end

	assign rack = (phase == CRL_DONE);

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_resp_taken;
		resp_valid && resp_ready && resp_last;
	endsequence

	a_rack_after_resp: assert property (@(posedge mclk) disable iff (!rst_s2)
		s_resp_taken |-> ##2 rack)
		else $error("rack not two cycles after response");
	a_end_in_legal: assert property (@(posedge mclk) disable iff (!rst_s2)
		rack && !start_err |-> (legal_set & crl_pkg::crl_bit(end_state)) != 5'h00)
		else $error("end state outside legal set");
	a_err_dirty: assert property (@(posedge mclk) disable iff (!rst_s2)
		s_resp_taken ##0 resp_bits[0] |=> proto_err)
		else $error("dirty response not flagged");
	a_no_resp_snoop: assert property (@(posedge mclk) disable iff (!rst_s2)
		snoop_hit && phase == CRL_WAIT |-> !resp_ready)
		else $error("response taken during same-line snoop");
	a_once_vacant: assert property (@(posedge mclk) disable iff (!rst_s2)
		phase == CRL_LOOK && op == crl_pkg::CRL_RD_ONCE && cur == crl_pkg::CRL_VACANT
		|=> end_state == crl_pkg::CRL_VACANT)
		else $error("snapshot read allocated a line");
	a_filter_subset: assert property (@(posedge mclk) disable iff (!rst_s2)
		(tab[9:5] & ~tab[4:0]) == 5'h00)
		else $error("filter set not inside no-filter set");
	a_unique_demote: assert property (@(posedge mclk) disable iff (!rst_s2)
		tab[5 + crl_pkg::CRL_B_UD] |-> tab[5 + crl_pkg::CRL_B_SD])
		else $error("dirty unique not demotable");
	a_rack_single: assert property (@(posedge mclk) disable iff (!rst_s2)
		rack |=> !rack)
		else $error("rack longer than one cycle");
endmodule

// ---- sim/crl_icn_model.sv ----
/*
 Behavioural coherent interconnect: answers one read at a time with
 two beats. Assumes the bench supplies the response bits and delay.
*/
`timescale 1ns/1ps
module crl_icn_model (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic resp_ready,
	input wire logic [1:0] bits_in,
	input wire logic [3:0] delay,
	output logic resp_valid,
	output logic resp_last,
	output logic [1:0] resp_bits
);
	logic [3:0] wait_cnt;
	logic pend;

	// ****************************************
	// Response sequencer
	// ****************************************
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pend <= 1'h0;
			wait_cnt <= 4'h0;
			resp_valid <= 1'h0;
			resp_last <= 1'h0;
			resp_bits <= 2'h3;
		end else if (req_valid && req_ready) begin
			pend <= 1'h1;
			wait_cnt <= delay;
		end else if (pend && !resp_valid) begin
			if (wait_cnt == 4'h0) begin
				resp_valid <= 1'h1;
				// Bench breaks the dirty rule only in error cases
				resp_bits <= bits_in;
			end else begin
				wait_cnt <= wait_cnt - 4'h1;
			end
		end else if (resp_valid && resp_ready) begin
			if (resp_last) begin
				resp_valid <= 1'h0;
				resp_last <= 1'h0;
				pend <= 1'h0;
				// Released bits must not look valid
				resp_bits <= ~resp_bits;
			end else begin
				resp_last <= 1'h1;
			end
		end
	end
endmodule

// ---- sim/tb_coherent_read_line_state_update.sv ----
/*
 Self-checking bench for the read line-state update block.
 Assumes the interconnect model is compiled before it.
*/
`timescale 1ns/1ps
module tb_coherent_read_line_state_update;
	typedef struct {
		logic [1:0] op;
		logic [2:0] st;
		logic [1:0] rb;
		logic filt;
		logic use_e;
		logic [2:0] pick;
		logic [2:0] fin;
		logic [4:0] ex;
		logic [4:0] lg;
	} crl_row_t;
	logic mclk, rst_b, snoop_filter, use_expected, req_valid, req_spec, req_ready;
	logic req_refused, snoop_valid, resp_valid, resp_last, resp_ready, rack;
	logic proto_err, start_err, busy, pe_seen, se_seen;
	logic [1:0] resp_bits, bits_in;
	logic [3:0] req_idx, snoop_idx, delay;
	logic [4:0] expected_set, legal_set, cap_ex, cap_lg;
	crl_pkg::crl_state_t pick_state, snoop_state, end_state, cap_end;
	crl_pkg::crl_op_t req_op;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	crl_row_t rows [13] = '{
		'{2'h0, 3'h0, 2'h0, 1'h1, 1'h1, 3'h0, 3'h1, 5'h03, 5'h0B},
		'{2'h0, 3'h1, 2'h0, 1'h0, 1'h1, 3'h0, 3'h1, 5'h03, 5'h0B},
		'{2'h0, 3'h4, 2'h0, 1'h1, 1'h1, 3'h0, 3'h2, 5'h04, 5'h14},
		'{2'h0, 3'h3, 2'h0, 1'h1, 1'h0, 3'h0, 3'h0, 5'h03, 5'h0B},
		'{2'h1, 3'h0, 2'h2, 1'h0, 1'h1, 3'h0, 3'h0, 5'h01, 5'h01},
		'{2'h1, 3'h3, 2'h0, 1'h1, 1'h1, 3'h0, 3'h1, 5'h02, 5'h0A},
		'{2'h1, 3'h2, 2'h0, 1'h0, 1'h0, 3'h4, 3'h4, 5'h04, 5'h14},
		'{2'h2, 3'h4, 2'h2, 1'h0, 1'h1, 3'h0, 3'h4, 5'h10, 5'h10},
		'{2'h2, 3'h3, 2'h2, 1'h0, 1'h0, 3'h0, 3'h0, 5'h08, 5'h09},
		'{2'h2, 3'h0, 2'h0, 1'h1, 1'h0, 3'h0, 3'h1, 5'h02, 5'h0A},
		'{2'h2, 3'h0, 2'h0, 1'h0, 1'h0, 3'h0, 3'h0, 5'h02, 5'h0B},
		'{2'h2, 3'h0, 2'h2, 1'h1, 1'h0, 3'h3, 3'h3, 5'h08, 5'h08},
		'{2'h1, 3'h4, 2'h2, 1'h1, 1'h0, 3'h2, 3'h4, 5'h10, 5'h10}
	};

	crl_update u_dut (.mclk(mclk), .rst_b(rst_b), .snoop_filter(snoop_filter),
		.use_expected(use_expected), .pick_state(pick_state), .req_valid(req_valid),
		.req_op(req_op), .req_idx(req_idx), .req_spec(req_spec), .req_ready(req_ready),
		.req_refused(req_refused), .snoop_valid(snoop_valid), .snoop_idx(snoop_idx),
		.snoop_state(snoop_state), .resp_valid(resp_valid), .resp_last(resp_last),
		.resp_bits(resp_bits), .resp_ready(resp_ready), .rack(rack), .end_state(end_state),
		.expected_set(expected_set), .legal_set(legal_set), .proto_err(proto_err),
		.start_err(start_err), .busy(busy));
	crl_icn_model u_icn (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid),
		.req_ready(req_ready), .resp_ready(resp_ready), .bits_in(bits_in), .delay(delay),
		.resp_valid(resp_valid), .resp_last(resp_last), .resp_bits(resp_bits));

	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end

	// Error pulses stand one cycle, so latch them
	always @(negedge mclk) begin
		if (proto_err === 1'b1) pe_seen = 1'h1;
		if (start_err === 1'b1) se_seen = 1'h1;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			give_verdict();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [4:0] seen, input logic [4:0] want);
		num_checks++;
		if (seen !== want) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic put(input logic [3:0] idx, input logic [2:0] st);
		@(negedge mclk);
		snoop_valid = 1'h1;
		snoop_idx = idx;
		snoop_state = crl_pkg::crl_state_t'(st);
		@(negedge mclk);
		snoop_valid = 1'h0;
	endtask

	task automatic do_read(input logic [1:0] op, input logic [3:0] idx, input logic [1:0] rb,
		input logic [3:0] dly, input logic snp, input logic [2:0] sst);
		int n;
		n = 0;
		pe_seen = 1'h0;
		se_seen = 1'h0;
		@(negedge mclk);
		req_valid = 1'h1;
		req_op = crl_pkg::crl_op_t'(op);
		req_idx = idx;
		bits_in = rb;
		delay = dly;
		@(negedge mclk);
		req_valid = 1'h0;
		check({4'h0, req_refused}, 5'h00);
		// Snoop lands while the read is outstanding
		if (snp) put(idx, sst);
		while (rack !== 1'b1 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		check({4'h0, rack}, 5'h01);
		cap_end = end_state;
		cap_ex = expected_set;
		cap_lg = legal_set;
		@(negedge mclk);
		check({4'h0, rack}, 5'h00);
	endtask

	task automatic give_verdict();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst_b, snoop_filter, req_valid, req_spec, snoop_valid} = 5'h00;
		{use_expected, req_idx, snoop_idx, bits_in, delay} = 15'h4000;
		pick_state = crl_pkg::CRL_VACANT;
		snoop_state = crl_pkg::CRL_VACANT;
		req_op = crl_pkg::CRL_RD_NOSNOOP;
		repeat (5) @(negedge mclk);
		rst_b = 1'h1;
		repeat (3) @(negedge mclk);
		check({4'h0, busy}, 5'h00);
		check({2'h0, end_state}, 5'h00);
		do_read(2'h1, 4'hF, 2'h2, 4'h0, 1'h0, 3'h0);
		check({2'h0, cap_end}, 5'h00);
		$display("reset test done");
		for (int i = 0; i < 13; i++) begin
			put(i[3:0], rows[i].st);
			snoop_filter = rows[i].filt;
			use_expected = rows[i].use_e;
			pick_state = crl_pkg::crl_state_t'(rows[i].pick);
			req_spec = (rows[i].st != 3'h0);
			do_read(rows[i].op, i[3:0], rows[i].rb, i[0] ? 4'h6 : 4'h0, 1'h0, 3'h0);
			check({2'h0, cap_end}, {2'h0, rows[i].fin});
			check(cap_ex, rows[i].ex);
			check(cap_lg, rows[i].lg);
			check({3'h0, pe_seen, se_seen}, 5'h00);
			$display("row %0d done", i);
		end
		{use_expected, snoop_filter, req_spec} = 3'h4;
		do_read(2'h2, 4'hD, 2'h2, 4'h8, 1'h1, 3'h4);
		check({2'h0, cap_end}, 5'h04);
		check(cap_ex, 5'h10);
		$display("snoop test done");
		req_spec = 1'h1;
		put(4'hE, 3'h1);
		do_read(2'h2, 4'hE, 2'h2, 4'h2, 1'h0, 3'h0);
		check({4'h0, se_seen}, 5'h01);
		do_read(2'h1, 4'hE, 2'h0, 4'h0, 1'h0, 3'h0);
		check({2'h0, cap_end}, 5'h01);
		$display("undefined start test done");
		do_read(2'h0, 4'hC, 2'h2, 4'h1, 1'h0, 3'h0);
		check({4'h0, pe_seen}, 5'h01);
		do_read(2'h2, 4'hC, 2'h1, 4'h3, 1'h0, 3'h0);
		check({4'h0, pe_seen}, 5'h01);
		$display("error response test done");
		// Line 2 was left dirty by the table rows; reset must clear it
		@(negedge mclk);
		rst_b = 1'h0;
		repeat (2) @(negedge mclk);
		rst_b = 1'h1;
		repeat (3) @(negedge mclk);
		check({4'h0, busy}, 5'h00);
		do_read(2'h1, 4'h2, 2'h0, 4'h0, 1'h0, 3'h0);
		check({2'h0, cap_end}, 5'h00);
		$display("mid-run reset test done");
		give_verdict();
	end
endmodule
